//--- verilog/sgp_defs.vh
/*
  Constants of the segment port and analog input port block: register
  indices, field positions, reset values and selection codes.
  Assumes it is included by its bare name from the pin mux and top design files.
*/
`ifndef SGP_DEFS_VH
`define SGP_DEFS_VH

// Register indices; the bus byte address is four times the index
`define SGP_IDX_ANALOG_LEVELS   16'hFFA2
`define SGP_IDX_ANALOG_DISABLE  16'hFFA4
`define SGP_IDX_SEG_DATA        16'hFFC8
`define SGP_IDX_SEG_DIR         16'hFFCA
`define SGP_IDX_STARTUP_CFG     16'hFF20
`define SGP_IDX_RESET_CFG       16'hFF22

// Bus geometry
`define SGP_ADDR_W              18
`define SGP_BYTE_LSBS           2'b00

// Segment line count field, same place in startup and reset config words
`define SGP_SEL_HI              12
`define SGP_SEL_LO              11

// Segment line count codes and the pins each code hands to the address
`define SGP_SEL_64K             2'b01
`define SGP_SEL_256K            2'b11
`define SGP_SEL_1M              2'b00
`define SGP_SEL_16M             2'b10
`define SGP_MASK_64K            8'h00
`define SGP_MASK_256K           8'h03
`define SGP_MASK_1M             8'h0F
`define SGP_MASK_16M            8'hFF

// Reset values
`define SGP_RST_BYTE            8'h00
`define SGP_RST_WORD            16'h0000
`define SGP_RST_CAN             4'h0
`define SGP_ALL_ONES16          16'hFFFF
`define SGP_RST_BUS             32'h0000_0000

// Analog pins that also feed the timer unit
`define SGP_PIN_T6_UD           10
`define SGP_PIN_T5_UD           11
`define SGP_PIN_T6_CNT          12
`define SGP_PIN_T5_CNT          13
`define SGP_PIN_T4_UD           14
`define SGP_PIN_T2_UD           15

// First and last segment pins that a CAN module may claim
`define SGP_CAN_FIRST_PIN       4
`define SGP_CAN_LAST_PIN        7

// Byte lanes of the write data
`define SGP_LANE_LO             0
`define SGP_LANE_HI             1

`endif

//--- verilog/sgp_sync.v
/*
  Three-stage pin synchroniser with a two-stage agreement filter.
  Assumes asynchronous pin levels; the filtered level is data, not
  control state, so it carries no reset and settles within four edges.
*/
`timescale 1ns/100ps
module sgp_sync #(
  parameter W = 8
) (
  input  wire         i_clk,    // Core clock
  input  wire [W-1:0] i_async,  // Raw pin levels
  output wire [W-1:0] o_level   // Filtered, synchronised levels
);

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg lvl_q;
      // The first stage feeds only the second stage
      always @(posedge i_clk) begin
        s1_q <= i_async[g];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          lvl_q <= s3_q;
        end
      end
      assign o_level[g] = lvl_q;
    end
  endgenerate

endmodule

//--- verilog/sgp_pinmux.v
/*
  Per-pin function selection of the eight-pin segment port.
  Assumes all inputs are on the core clock; the outputs are combinational
  and are registered by the parent before they reach the pins.
*/
`timescale 1ns/100ps
`include "sgp_defs.vh"
module sgp_pinmux (
  input  wire [1:0] i_sel,        // Segment line count code
  input  wire [7:0] i_gpio_data,  // Port data latch
  input  wire [7:0] i_gpio_dir,   // Port direction, 1 = output
  input  wire [7:0] i_seg_addr,   // Segment address A16..A23
  input  wire [3:0] i_can_claim,  // CAN claims pins 4..7
  input  wire [3:0] i_can_tx,     // CAN drive values for pins 4..7
  input  wire [3:0] i_can_oe,     // CAN drive enables for pins 4..7
  output wire [7:0] o_pin_out,    // Next pin drive value
  output wire [7:0] o_pin_oe      // Next pin drive enable
);

  function [7:0] seg_mask;
    input [1:0] sel;
    begin
      case (sel)
        `SGP_SEL_64K:  seg_mask = `SGP_MASK_64K;
        `SGP_SEL_256K: seg_mask = `SGP_MASK_256K;
        `SGP_SEL_1M:   seg_mask = `SGP_MASK_1M;
        default:       seg_mask = `SGP_MASK_16M;
      endcase
    end
  endfunction

  wire [7:0] mask;
  assign mask = seg_mask(i_sel);  // [RULE5] [RULE1]

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      wire can;
      wire can_tx;
      wire can_oe;
      if (g >= `SGP_CAN_FIRST_PIN) begin : g_can
        assign can    = i_can_claim[g - `SGP_CAN_FIRST_PIN];  // [RULE6]
        assign can_tx = i_can_tx[g - `SGP_CAN_FIRST_PIN];
        assign can_oe = i_can_oe[g - `SGP_CAN_FIRST_PIN];
      end else begin : g_nocan
        assign can    = 1'b0;
        assign can_tx = 1'b0;
        assign can_oe = 1'b0;
      end
      // CAN first, then segment address, then the port latches
      assign o_pin_out[g] = can ? can_tx :
                            mask[g] ? i_seg_addr[g] : i_gpio_data[g];  // [RULE7] [RULE18]
      assign o_pin_oe[g]  = can ? can_oe :
                            mask[g] ? 1'b1 : i_gpio_dir[g];  // [RULE7] [RULE8] [RULE17]
    end
  endgenerate

endmodule

//--- verilog/sgp_top.v
/*
  Segment port and analog input port: pin function selection for the
  eight-pin segment/CAN/GPIO port, the sixteen-pin analog input port with
  digital input disable, and their registers on an Avalon-MM slave.
  Assumes pins are asynchronous, while bus, segment address and CAN lines
  run on the core clock. Reset is synchronous, active high.
*/
// Decided for this implementation: the Avalon-MM slave port.
// What this block does
// RULE1 - Drive selected segment lines during bus cycles
// RULE2 - Segment lines active after reset, no software
// RULE3 - Line count strapped from boot port at reset
// RULE4 - Software rewrites line count via reset config
// RULE5 - Decode count code into pin masks
// RULE6 - CAN may claim two or four upper pins
// RULE7 - CAN beats address and GPIO on pin
// RULE8 - Unassigned pins stay latch-controlled GPIO
// RULE9 - Analog port input only, writes dropped
// RULE10 - Analog data read returns current pins
// RULE11 - Analog pin y feeds converter channel y
// RULE12 - Pins ten to fifteen feed timer inputs
// RULE13 - Disable bit cuts pin digital input
// RULE14 - Software disables inputs of analog pins
// RULE15 - All digital inputs connected after reset
// RULE16 - Disconnected input reads as one everywhere
// RULE17 - Direction zero input, one output
// RULE18 - Address pins ignore latch and direction
`timescale 1ns/100ps
`include "sgp_defs.vh"
module sgp_top (
  input  wire                   i_core_clk,         // Core clock, 40 MHz
  input  wire                   i_sys_rst,          // Synchronous reset, active high
  input  wire [`SGP_ADDR_W-1:0] i_avs_address,      // Avalon byte address
  input  wire                   i_avs_read,         // Avalon read request
  input  wire                   i_avs_write,        // Avalon write request
  input  wire [31:0]            i_avs_writedata,    // Avalon write data
  input  wire [3:0]             i_avs_byteenable,   // Avalon byte enables
  output reg  [31:0]            o_avs_readdata,     // Avalon read data
  output reg                    o_avs_waitrequest,  // Avalon wait request
  input  wire [15:0]            i_boot_config_port, // Boot strap pins
  input  wire [7:0]             i_seg_addr,         // Segment address A16..A23
  input  wire [3:0]             i_can_claim,        // CAN claims pins 4..7
  input  wire [3:0]             i_can_tx,           // CAN drive values pins 4..7
  input  wire [3:0]             i_can_oe,           // CAN drive enables pins 4..7
  input  wire [7:0]             i_seg_pin_in,       // Segment port pin levels
  output reg  [7:0]             o_seg_pin_out,      // Segment port drive values
  output reg  [7:0]             o_seg_pin_oe,       // Segment port drive enables
  output reg  [3:0]             o_can_rx,           // Pin levels of pins 4..7 to CAN
  input  wire [15:0]            i_analog_pin,       // Analog port pin levels
  output reg  [15:0]            o_analog_channel,   // Levels toward converter mux
  output reg                    o_timer6_updown_in, // Timer 6 up/down input
  output reg                    o_timer5_updown_in, // Timer 5 up/down input
  output reg                    o_timer6_count_in,  // Timer 6 count input
  output reg                    o_timer5_count_in,  // Timer 5 count input
  output reg                    o_timer4_updown_in, // Timer 4 up/down input
  output reg                    o_timer2_updown_in  // Timer 2 up/down input
);

  // Synchronised pin levels
  wire [15:0] boot_lvl;
  wire [7:0]  seg_lvl;
  wire [15:0] an_lvl;

  sgp_sync #(
    .W (16)
  ) u_sync_boot (
    .i_clk   (i_core_clk),
    .i_async (i_boot_config_port),
    .o_level (boot_lvl)
  );

  sgp_sync #(
    .W (8)
  ) u_sync_seg (
    .i_clk   (i_core_clk),
    .i_async (i_seg_pin_in),
    .o_level (seg_lvl)
  );

  sgp_sync #(
    .W (16)
  ) u_sync_an (
    .i_clk   (i_core_clk),
    .i_async (i_analog_pin),
    .o_level (an_lvl)
  );

  // Register state
  reg  [15:0] startup_q;
  reg  [1:0]  sel_q;
  reg  [7:0]  seg_data_q;
  reg  [7:0]  seg_dir_q;
  reg  [15:0] didis_q;

  function hit;
    input [`SGP_ADDR_W-1:0] addr;
    input [15:0]            idx;
    begin
      hit = (addr == {idx, `SGP_BYTE_LSBS});
    end
  endfunction

  // Digital view of the analog port: a cut-off stage reads as one
  wire [15:0] an_dig;
  assign an_dig = an_lvl | didis_q;  // [RULE13] [RULE16]

  // Bus slave: the answer is prepared on the edge that first sees the request,
  // and a write lands on the edge where the master sees waitrequest low.
  wire req;
  wire accept;
  assign req    = i_avs_read | i_avs_write;
  assign accept = req & ~o_avs_waitrequest;

  wire hit_an;
  wire hit_dis;
  wire hit_data;
  wire hit_dir;
  wire hit_start;
  wire hit_rcfg;
  assign hit_an    = hit(i_avs_address, `SGP_IDX_ANALOG_LEVELS);
  assign hit_dis   = hit(i_avs_address, `SGP_IDX_ANALOG_DISABLE);
  assign hit_data  = hit(i_avs_address, `SGP_IDX_SEG_DATA);
  assign hit_dir   = hit(i_avs_address, `SGP_IDX_SEG_DIR);
  assign hit_start = hit(i_avs_address, `SGP_IDX_STARTUP_CFG);
  assign hit_rcfg  = hit(i_avs_address, `SGP_IDX_RESET_CFG);

  wire wr;
  assign wr = accept & i_avs_write;

  // One strobe per writable register, two for the disable register, each gated by the byte lane that it uses
  wire we_data;
  wire we_dir;
  wire we_dis_lo;
  wire we_dis_hi;
  wire we_rcfg;
  assign we_data   = wr & hit_data & i_avs_byteenable[`SGP_LANE_LO];
  assign we_dir    = wr & hit_dir & i_avs_byteenable[`SGP_LANE_LO];
  assign we_dis_lo = wr & hit_dis & i_avs_byteenable[`SGP_LANE_LO];
  assign we_dis_hi = wr & hit_dis & i_avs_byteenable[`SGP_LANE_HI];
  assign we_rcfg   = wr & hit_rcfg & i_avs_byteenable[`SGP_LANE_HI];

  reg [15:0] rd_mux;
  always @* begin
    rd_mux = `SGP_RST_WORD;
    if (hit_an) begin
      rd_mux = an_dig;  // [RULE10]
    end else if (hit_dis) begin
      rd_mux = didis_q;
    end else if (hit_data) begin
      rd_mux = {8'h00, seg_data_q};
    end else if (hit_dir) begin
      rd_mux = {8'h00, seg_dir_q};
    end else if (hit_start) begin
      rd_mux = startup_q;
      rd_mux[`SGP_SEL_HI:`SGP_SEL_LO] = sel_q;
    end else if (hit_rcfg) begin
      rd_mux[`SGP_SEL_HI:`SGP_SEL_LO] = sel_q;
    end
  end

  // Handshake: one wait state, then an answer that stands for one cycle.
  // A request held high after completion simply starts the next transfer.
  localparam BUS_IDLE   = 1'b0;
  localparam BUS_ANSWER = 1'b1;

  reg bus_state_q;
  reg bus_state_d;

  always @* begin
    case (bus_state_q)
      BUS_IDLE: begin
        bus_state_d = req ? BUS_ANSWER : BUS_IDLE;
      end
      BUS_ANSWER: begin
        bus_state_d = BUS_IDLE;
      end
      default: begin
        bus_state_d = BUS_IDLE;
      end
    endcase
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      bus_state_q       <= BUS_IDLE;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= `SGP_RST_BUS;
    end else begin
      bus_state_q       <= bus_state_d;
      o_avs_waitrequest <= (bus_state_d != BUS_ANSWER);
      if (bus_state_d == BUS_ANSWER) begin
        // Unmapped addresses read as zero; the mux already yields that
        o_avs_readdata <= {16'h0000, rd_mux};
      end
    end
  end

  // Strap capture: the boot levels are taken on every reset edge, so the
  // last edge of reset holds the value; reset must outlast the synchroniser.
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      startup_q <= boot_lvl;  // [RULE3]
    end
  end

  // Software may move the line count at any time after reset
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      sel_q <= boot_lvl[`SGP_SEL_HI:`SGP_SEL_LO];  // [RULE3] [RULE2]
    end else if (we_rcfg) begin
      sel_q <= i_avs_writedata[`SGP_SEL_HI:`SGP_SEL_LO];  // [RULE4]
    end
  end

  // Port latches and direction
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      seg_data_q <= `SGP_RST_BYTE;
      seg_dir_q  <= `SGP_RST_BYTE;
    end else begin
      if (we_data) begin
        seg_data_q <= i_avs_writedata[7:0];
      end
      if (we_dir) begin
        seg_dir_q <= i_avs_writedata[7:0];
      end
      // A write to the analog level register has no target at all [RULE9]
    end
  end

  // Digital input disable, each byte lane written under its own enable
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      didis_q <= `SGP_RST_WORD;  // [RULE15]
    end else begin
      if (we_dis_lo) begin
        didis_q[7:0] <= i_avs_writedata[7:0];  // [RULE13]
      end
      if (we_dis_hi) begin
        didis_q[15:8] <= i_avs_writedata[15:8];
      end
    end
  end

  // Segment port pin selection
  wire [7:0] pin_out_d;
  wire [7:0] pin_oe_d;

  sgp_pinmux u_pinmux (
    .i_sel       (sel_q),
    .i_gpio_data (seg_data_q),
    .i_gpio_dir  (seg_dir_q),
    .i_seg_addr  (i_seg_addr),
    .i_can_claim (i_can_claim),
    .i_can_tx    (i_can_tx),
    .i_can_oe    (i_can_oe),
    .o_pin_out   (pin_out_d),
    .o_pin_oe    (pin_oe_d)
  );

  // Pins leave through flops; the segment lines come up driven in the
  // first edge after reset, before any software runs.
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_seg_pin_out <= `SGP_RST_BYTE;
      o_seg_pin_oe  <= `SGP_RST_BYTE;
    end else begin
      o_seg_pin_out <= pin_out_d;  // [RULE1] [RULE2]
      o_seg_pin_oe  <= pin_oe_d;   // [RULE2] [RULE17]
    end
  end

  // Receive levels come from the synchronised pin, whatever drives it
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_can_rx <= `SGP_RST_CAN;
    end else begin
      o_can_rx <= seg_lvl[`SGP_CAN_LAST_PIN:`SGP_CAN_FIRST_PIN];  // [RULE6]
    end
  end

  // Converter channels follow the pins even while a digital stage is cut
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_analog_channel <= `SGP_RST_WORD;
    end else begin
      o_analog_channel <= an_lvl;  // [RULE11]
    end
  end

  // Timer inputs see the digital view, so a cut stage holds them at one
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_timer6_updown_in <= 1'b1;
      o_timer5_updown_in <= 1'b1;
      o_timer6_count_in  <= 1'b1;
      o_timer5_count_in  <= 1'b1;
      o_timer4_updown_in <= 1'b1;
      o_timer2_updown_in <= 1'b1;
    end else begin
      o_timer6_updown_in <= an_dig[`SGP_PIN_T6_UD];    // [RULE12] [RULE16]
      o_timer5_updown_in <= an_dig[`SGP_PIN_T5_UD];    // [RULE12]
      o_timer6_count_in  <= an_dig[`SGP_PIN_T6_CNT];   // [RULE12]
      o_timer5_count_in  <= an_dig[`SGP_PIN_T5_CNT];   // [RULE12]
      o_timer4_updown_in <= an_dig[`SGP_PIN_T4_UD];    // [RULE12]
      o_timer2_updown_in <= an_dig[`SGP_PIN_T2_UD];    // [RULE12]
    end
  end

endmodule

//--- sim/sgp_properties.sv
/*
  Port timing checker for sgp_top.
  Assumes it is bound to sgp_top and sees only its ports.
*/
`timescale 1ns/100ps
module sgp_checker (
  input logic        i_core_clk,        // Clock
  input logic        i_sys_rst,         // Reset
  input logic [17:0] i_avs_address,     // Address
  input logic        i_avs_read,        // Read
  input logic        i_avs_write,       // Write
  input logic [31:0] o_avs_readdata,    // Read data
  input logic        o_avs_waitrequest, // Wait
  input logic [3:0]  i_can_claim,       // CAN claims
  input logic [3:0]  i_can_tx,          // CAN values
  input logic [3:0]  i_can_oe,          // CAN enables
  input logic [7:0]  o_seg_pin_out,     // Pin values
  input logic [7:0]  o_seg_pin_oe,      // Pin enables
  input logic [15:0] i_analog_pin,      // Analog pins
  input logic [15:0] o_analog_channel,  // Channels
  input logic        o_timer6_count_in  // Timer input
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  wire rq = i_avs_read | i_avs_write;
  property p_can_out;
    |i_can_claim |=> ((o_seg_pin_out[7:4] ^ $past(i_can_tx)) & $past(i_can_claim)) == 4'h0;
  endproperty
  a_can_out: assert property (p_can_out) else $error("CAN value lost on pin");
  property p_can_oe;
    |i_can_claim |=> ((o_seg_pin_oe[7:4] ^ $past(i_can_oe)) & $past(i_can_claim)) == 4'h0;
  endproperty
  a_can_oe: assert property (p_can_oe) else $error("CAN enable lost on pin");
  // Eight quiet cycles cover the synchroniser and filter delay
  property p_chan;
    ($stable(i_analog_pin))[*8] |-> o_analog_channel == i_analog_pin;
  endproperty
  a_chan: assert property (p_chan) else $error("channel differs from pin");
  property p_timer;
    ($stable(i_analog_pin) && i_analog_pin[12])[*8] |-> o_timer6_count_in;
  endproperty
  a_timer: assert property (p_timer) else $error("timer input not high");
  property p_rd_pins;
    ($stable(i_analog_pin))[*8] ##0
      (i_avs_read && !o_avs_waitrequest && i_avs_address == 18'h3FE88)
      |-> (o_avs_readdata[15:0] & i_analog_pin) == i_analog_pin;
  endproperty
  a_rd_pins: assert property (p_rd_pins) else $error("pin level read wrong");
  property p_wait_cause;
    !o_avs_waitrequest |-> $past(rq);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
  property p_wait_answer;
    rq && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("answer late");
  property p_wait_one;
    !o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer held too long");
  c_can: cover property (|i_can_claim);
  c_wr: cover property (!o_avs_waitrequest && i_avs_write);
  c_rd: cover property (!o_avs_waitrequest && i_avs_read && i_avs_address == 18'h3FE88);
endmodule

bind sgp_top sgp_checker u_chk (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_can_claim(i_can_claim), .i_can_tx(i_can_tx),
  .i_can_oe(i_can_oe), .o_seg_pin_out(o_seg_pin_out), .o_seg_pin_oe(o_seg_pin_oe),
  .i_analog_pin(i_analog_pin), .o_analog_channel(o_analog_channel),
  .o_timer6_count_in(o_timer6_count_in));

//--- sim/sgp_pins_model.sv
/*
  Far side of the segment port: memory bus and transceiver pins.
  Assumes no pull device: a released pin shows the inverse of the level
  last driven onto it, so a stale read of a released pin never looks right.
*/
`timescale 1ns/100ps
module sgp_pins_model (
  input  logic       i_clk,     // Clock
  input  logic [7:0] i_pin_out, // Drive values
  input  logic [7:0] i_pin_oe,  // Drive enables
  output logic [7:0] o_pin_in   // Pin levels
);
  logic [7:0] held_q = 8'h00;
  always @(posedge i_clk) held_q <= (i_pin_out & i_pin_oe) | (held_q & ~i_pin_oe);
  assign o_pin_in = (i_pin_out & i_pin_oe) | (~held_q & ~i_pin_oe);
endmodule

//--- sim/segment_port_and_analog_input_port_test.sv
/*
  Self-checking bench for sgp_top with a pin model.
  Assumes the checker is bound in and a 40 MHz core clock.
*/
`timescale 1ns/100ps
module segment_port_and_analog_input_port_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [17:0] adr = 18'h0;
  logic rd = 1'b0, wr = 1'b0;
  logic [31:0] wd = 32'h0, got, rdat;
  logic [3:0] be = 4'h0, cl = 4'h0, ctx = 4'h0, coe = 4'h0, crx;
  logic [7:0] sa = 8'hC6, pin_in, pout, poe;
  logic [15:0] ana = 16'h0, chan, boot = 16'h1000;
  logic [5:0] tmr;
  logic wq;
  int n_fail = 0;
  int checked = 0;
  sgp_top DUT (.i_core_clk(clk), .i_sys_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wq), .i_boot_config_port(boot), .i_seg_addr(sa),
    .i_can_claim(cl), .i_can_tx(ctx), .i_can_oe(coe), .i_seg_pin_in(pin_in),
    .o_seg_pin_out(pout), .o_seg_pin_oe(poe), .o_can_rx(crx), .i_analog_pin(ana),
    .o_analog_channel(chan), .o_timer6_updown_in(tmr[0]), .o_timer5_updown_in(tmr[1]),
    .o_timer6_count_in(tmr[2]), .o_timer5_count_in(tmr[3]), .o_timer4_updown_in(tmr[4]),
    .o_timer2_updown_in(tmr[5]));
  sgp_pins_model u_pins (.i_clk(clk), .i_pin_out(pout), .i_pin_oe(poe), .o_pin_in(pin_in));
  initial forever #12.5 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Holds the request until waitrequest is sampled low, then drops it
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d,
                     input logic [3:0] b);
    @(posedge clk);
    adr <= {idx, 2'h0};
    wr <= w;
    rd <= !w;
    wd <= d;
    be <= b;
    @(posedge clk);
    while (wq !== 1'b0) begin
      @(posedge clk);
    end
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task t_reset;
    bus(0, 16'hFF20, 32'h0, 4'h0);
    check(got & 32'h1800, 32'h1000);
    bus(0, 16'hFFA4, 32'h0, 4'h0);
    check(got, 32'h0);
    check({24'h0, poe}, 32'hFF);
    check({24'h0, pout}, {24'h0, sa});
  endtask
  task t_sel;
    logic [1:0] c [4];
    logic [7:0] m [4];
    c = '{2'h1, 2'h3, 2'h0, 2'h2};
    m = '{8'h00, 8'h03, 8'h0F, 8'hFF};
    bus(1, 16'hFFC8, 32'h00A5, 4'h1);
    bus(1, 16'hFFCA, 32'h00F0, 4'h1);
    for (int i = 0; i < 4; i++) begin
      sa <= sa + 8'h3B;
      bus(1, 16'hFF22, {c[i], 11'h0}, 4'h2);
      bus(0, 16'hFF22, 32'h0, 4'h0);
      check(got & 32'h1800, {c[i], 11'h0});
      repeat (2) @(posedge clk);
      check({24'h0, poe}, {24'h0, m[i] | (~m[i] & 8'hF0)});
      check({24'h0, pout}, {24'h0, (sa & m[i]) | (8'hA5 & ~m[i])});
    end
  endtask
  task t_can;
    cl <= 4'h5;
    ctx <= 4'h1;
    coe <= 4'h3;
    repeat (3) @(posedge clk);
    check({24'h0, poe}, 32'hBF);
    check({24'h0, pout}, {24'h0, (sa & 8'hAF) | 8'h10});
    cl <= 4'hF;
    ctx <= 4'hA;
    coe <= 4'hF;
    repeat (8) @(posedge clk);
    check({24'h0, pout}, {24'h0, 4'hA, sa[3:0]});
    check({28'h0, crx}, 32'hA);
    cl <= 4'h0;
  endtask
  task t_analog;
    ana <= 16'h5A3C;
    repeat (8) @(posedge clk);
    bus(0, 16'hFFA2, 32'h0, 4'h0);
    check(got, 32'h5A3C);
    check({16'h0, chan}, 32'h5A3C);
    check({26'h0, tmr}, 32'h16);
    bus(1, 16'hFFA2, 32'hFFFF, 4'h3);
    bus(0, 16'hFFA2, 32'h0, 4'h0);
    check(got, 32'h5A3C);
    // Pin 0 and the timer pins are taken as analog inputs here
    bus(1, 16'hFFA4, 32'hFC01, 4'h3);
    bus(0, 16'hFFA2, 32'h0, 4'h0);
    check(got, 32'hFE3D);
    check({26'h0, tmr}, 32'h3F);
    check({16'h0, chan}, 32'h5A3C);
    bus(1, 16'hFFA4, 32'h0, 4'h1);
    bus(0, 16'hFFA4, 32'h0, 4'h0);
    check(got, 32'hFC00);
    bus(1, 16'h0004, 32'hFFFF, 4'hF);
    bus(0, 16'h0004, 32'h0, 4'h0);
    check(got, 32'h0);
  endtask
  // Second reset with another strap word: a 64 KB start leaves all pins to GPIO
  task t_restrap;
    boot <= 16'h0A5A;
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    bus(0, 16'hFF20, 32'h0, 4'h0);
    check(got, 32'h0A5A);
    bus(0, 16'hFFA4, 32'h0, 4'h0);
    check(got, 32'h0);
    check({24'h0, poe}, 32'h0);
    check({24'h0, pout}, 32'h0);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    wrap_up;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_sel;
    t_can;
    t_analog;
    t_restrap;
    wrap_up;
  end
endmodule
